/* logic/rsd_regs.sv */
// Rail sleep and discharge register bank with APB slave
`timescale 1ns/10ps
module rsd_regs
  import rsd_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [RSD_AW-1:0]      paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   sleep_pin_sel,
  input  wire logic                   control_in3_sleep_pin1,
  input  wire logic                   control_in6_sleep_pin2,
  input  wire logic                   aux3_pin_enable,
  input  wire logic [RSD_VCODE_W-1:0] aux3_normal_voltage_code,
  input  wire logic [RSD_VCODE_W-1:0] aux3_sleep_voltage_code,
  input  wire logic [RSD_RAILS-2:0]   other_rail_enable,
  output logic                        aux3_enable,
  output logic                        aux3_sleep_active,
  output logic      [RSD_VCODE_W-1:0] aux3_voltage_code,
  output rsd_dsel_t                   discharge_select
);

  // ****************************************
  // APB decode
  // ****************************************
  logic access;
  logic wr_stb;
  logic hit_aux3;
  logic hit_d1;
  logic hit_d2;
  logic hit_d3;
  logic hit;

  assign access   = psel && penable;
  assign wr_stb   = access && pwrite;
  assign hit_aux3 = (paddr == RSD_ADDR_AUX3_CTRL);
  assign hit_d1   = (paddr == RSD_ADDR_DISCH1);
  assign hit_d2   = (paddr == RSD_ADDR_DISCH2);
  assign hit_d3   = (paddr == RSD_ADDR_DISCH3);
  assign hit      = hit_aux3 || hit_d1 || hit_d2 || hit_d3;
  assign pready   = 1'b1;
  assign pslverr  = access && !hit;

  // ****************************************
  // Aux3 control and rail outputs
  // ****************************************
  rsd_aux3_ctrl_s           ctrl_reg;
  rsd_aux3_ctrl_s           ctrl_next;
  logic                     sleep_pin;
  logic                     aux3_en_now;
  logic                     sleep_now;
  logic                     en_reg;
  logic                     en_next;
  logic                     slp_reg;
  logic                     slp_next;
  logic [RSD_VCODE_W-1:0]   vcode_reg;
  logic [RSD_VCODE_W-1:0]   vcode_next;

  assign sleep_pin   = sleep_pin_sel ? control_in6_sleep_pin2 : control_in3_sleep_pin1;
  assign aux3_en_now = aux3_pin_enable && ctrl_reg.aux3_force_off_n;
  assign sleep_now   = (ctrl_reg.aux3_sleep_select == RSD_SLEEP_ON) && !sleep_pin;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_stb && hit_aux3) begin
      ctrl_next = rsd_aux3_ctrl_s'(pwdata[5:0]);
    end
    en_next  = aux3_en_now;
    slp_next = sleep_now;
    vcode_next = sleep_now ? aux3_sleep_voltage_code : aux3_normal_voltage_code;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg  <= rsd_aux3_ctrl_s'(RSD_AUX3_RESET);
      en_reg    <= 1'b0;
      slp_reg   <= 1'b0;
      vcode_reg <= '0;
    end else begin
      ctrl_reg  <= ctrl_next;
      en_reg    <= en_next;
      slp_reg   <= slp_next;
      vcode_reg <= vcode_next;
    end
  end

  assign aux3_enable       = en_reg;
  assign aux3_sleep_active = slp_reg;
  assign aux3_voltage_code = vcode_reg;

  // ****************************************
  // Discharge fields
  // ****************************************
  logic [RSD_RAILS-1:0]            rail_en;
  logic [2*RSD_RAILS-1:0]          codes;

  assign rail_en = {other_rail_enable[RSD_RAILS-2:RSD_AUX3_RAIL], aux3_en_now,
                    other_rail_enable[RSD_AUX3_RAIL-1:0]};

  genvar gi;
  generate
    for (gi = 0; gi < RSD_RAILS; gi = gi + 1) begin : g_rail
      localparam int unsigned REG_N = gi / RSD_FIELDS_REG;
      localparam int unsigned POS   = (gi % RSD_FIELDS_REG) * RSD_CODE_W;
      logic reg_hit;
      assign reg_hit = (REG_N == 0) ? hit_d1 : ((REG_N == 1) ? hit_d2 : hit_d3);
      rsd_disch_cell u_cell (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr_en     (wr_stb && reg_hit),
        .wr_code   (pwdata[POS+1:POS]),
        .rail_en   (rail_en[gi]),
        .code      (codes[2*gi+1:2*gi]),
        .disch_sel (discharge_select[gi])
      );
    end
  endgenerate

  // ****************************************
  // Read data
  // ****************************************
  logic [31:0] rd_reg;
  logic [31:0] rd_next;

  always_comb begin
    rd_next = rd_reg;
    if (psel && !penable) begin
      case (1'b1)
        hit_aux3: rd_next = {26'h0, ctrl_reg};
        hit_d1:   rd_next = {24'h0, codes[7:0]};
        hit_d2:   rd_next = {24'h0, codes[15:8]};
        hit_d3:   rd_next = {26'h0, codes[21:16]};
        default:  rd_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_reg <= 32'h0;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign prdata = rd_reg;

  // ****************************************
  // Assertions
  // ****************************************
  property p_sleep_off;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_reg.aux3_sleep_select == RSD_SLEEP_OFF)
      |=> (aux3_voltage_code == $past(aux3_normal_voltage_code)) && !aux3_sleep_active;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep used while disabled");

  property p_sleep_on;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_reg.aux3_sleep_select == RSD_SLEEP_ON && !sleep_pin)
      |=> (aux3_voltage_code == $past(aux3_sleep_voltage_code)) && aux3_sleep_active;
  endproperty
  a_sleep_on: assert property (p_sleep_on) else $error("sleep code not used");

  property p_pin_pick;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_reg.aux3_sleep_select == RSD_SLEEP_ON && sleep_pin_sel
       && control_in6_sleep_pin2 && !control_in3_sleep_pin1) |=> !aux3_sleep_active;
  endproperty
  a_pin_pick: assert property (p_pin_pick) else $error("wrong sleep pin followed");

  property p_force_off;
    @(posedge pclk) disable iff (!presetn)
      (!ctrl_reg.aux3_force_off_n) |=> !aux3_enable;
  endproperty
  a_force_off: assert property (p_force_off) else $error("aux3 on while forced off");

  property p_aux3_map;
    @(posedge pclk) disable iff (!presetn)
      (wr_stb && hit_aux3) ##1 !psel ##1 (psel && !penable && !pwrite && hit_aux3)
      |=> (prdata == {26'h0, $past(pwdata[5:0], 3)});
  endproperty
  a_aux3_map: assert property (p_aux3_map) else $error("aux3 control readback wrong");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      rail_en[RSD_AUX3_RAIL] |=> (codes[17:16] == RSD_CODE_RESET);
  endproperty
  a_clear: assert property (p_clear) else $error("aux3 discharge not cleared");

  property p_d1_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_stb && hit_d1 && rail_en[3:0] == 4'h0) |=> (codes[7:0] == $past(pwdata[7:0]));
  endproperty
  a_d1_write: assert property (p_d1_write) else $error("first discharge write lost");

  property p_d2_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_stb && hit_d2 && rail_en[7:4] == 4'h0) |=> (codes[15:8] == $past(pwdata[7:0]));
  endproperty
  a_d2_write: assert property (p_d2_write) else $error("second discharge write lost");

  property p_d3_read;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_d3) |=> (prdata[31:6] == 26'h0);
  endproperty
  a_d3_read: assert property (p_d3_read) else $error("third discharge reserved bits set");

  property p_active;
    @(posedge pclk) disable iff (!presetn)
      (rail_en[0] && rail_en[4]) |=> (discharge_select[0] == 3'h0) ##1
      (discharge_select[4] == 3'h0 || !$past(rail_en[4]));
  endproperty
  a_active: assert property (p_active) else $error("discharge on enabled rail");

  c_sleep: cover property (@(posedge pclk) disable iff (!presetn)
    !aux3_sleep_active ##1 aux3_sleep_active);
  c_force: cover property (@(posedge pclk) disable iff (!presetn)
    aux3_pin_enable && !ctrl_reg.aux3_force_off_n);
  c_disch: cover property (@(posedge pclk) disable iff (!presetn)
    discharge_select[RSD_AUX3_RAIL] == RSD_DSEL_500);
  c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule // rsd_regs

/* logic/rsd_pkg.sv */
// Package: register map, field layout, reset values and types of the rail sleep/discharge bank
package rsd_pkg;

  // ****************************************
  // Register indices and byte addresses
  // ****************************************
  localparam int unsigned RSD_IDX_AUX3_CTRL = 'h29;
  localparam int unsigned RSD_IDX_DISCH1    = 'h40;
  localparam int unsigned RSD_IDX_DISCH2    = 'h41;
  localparam int unsigned RSD_IDX_DISCH3    = 'h42;

  localparam int unsigned RSD_AW = 12;
  localparam logic [RSD_AW-1:0] RSD_ADDR_AUX3_CTRL = RSD_AW'(RSD_IDX_AUX3_CTRL * 4);
  localparam logic [RSD_AW-1:0] RSD_ADDR_DISCH1    = RSD_AW'(RSD_IDX_DISCH1 * 4);
  localparam logic [RSD_AW-1:0] RSD_ADDR_DISCH2    = RSD_AW'(RSD_IDX_DISCH2 * 4);
  localparam logic [RSD_AW-1:0] RSD_ADDR_DISCH3    = RSD_AW'(RSD_IDX_DISCH3 * 4);

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int unsigned RSD_RAILS      = 11;
  localparam int unsigned RSD_FIELDS_REG = 4;
  localparam int unsigned RSD_CODE_W     = 2;
  localparam int unsigned RSD_VCODE_W    = 8;
  localparam int unsigned RSD_AUX3_RAIL  = 8;

  localparam logic [1:0] RSD_SLEEP_OFF  = 2'h0;
  localparam logic [1:0] RSD_SLEEP_ON   = 2'h3;
  localparam logic [5:0] RSD_AUX3_RESET = 6'h0c;
  localparam logic [1:0] RSD_CODE_RESET = 2'h0;

  localparam logic [1:0] RSD_DCODE_NONE = 2'h0;
  localparam logic [1:0] RSD_DCODE_100  = 2'h1;
  localparam logic [1:0] RSD_DCODE_200  = 2'h2;
  localparam logic [1:0] RSD_DCODE_500  = 2'h3;
  localparam logic [2:0] RSD_DSEL_NONE  = 3'h0;
  localparam logic [2:0] RSD_DSEL_100   = 3'h1;
  localparam logic [2:0] RSD_DSEL_200   = 3'h2;
  localparam logic [2:0] RSD_DSEL_500   = 3'h4;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [1:0] aux3_sleep_select;
    logic [2:0] reserved;
    logic       aux3_force_off_n;
  } rsd_aux3_ctrl_s;

  typedef logic [RSD_RAILS-1:0][2:0] rsd_dsel_t;

endpackage

/* logic/rsd_disch_cell.sv */
// One rail's discharge code field and its resistor path selection
`timescale 1ns/10ps
module rsd_disch_cell
  import rsd_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             wr_en,
  input  wire logic [1:0]       wr_code,
  input  wire logic             rail_en,
  output logic      [1:0]       code,
  output logic      [2:0]       disch_sel
);

  logic [1:0] code_reg;
  logic [1:0] code_next;
  logic [2:0] sel_reg;
  logic [2:0] sel_next;

  always_comb begin
    code_next = code_reg;
    if (wr_en) begin
      code_next = wr_code;
    end
    if (rail_en) begin
      code_next = RSD_CODE_RESET;
    end
    sel_next = RSD_DSEL_NONE;
    if (!rail_en) begin
      case (code_reg)
        RSD_DCODE_100: sel_next = RSD_DSEL_100;
        RSD_DCODE_200: sel_next = RSD_DSEL_200;
        RSD_DCODE_500: sel_next = RSD_DSEL_500;
        default:       sel_next = RSD_DSEL_NONE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_reg <= RSD_CODE_RESET;
      sel_reg  <= RSD_DSEL_NONE;
    end else begin
      code_reg <= code_next;
      sel_reg  <= sel_next;
    end
  end

  assign code      = code_reg;
  assign disch_sel = sel_reg;

  // ****************************************
  // Assertions
  // ****************************************
  property p_cell_clear;
    @(posedge pclk) disable iff (!presetn) rail_en |=> (code == RSD_CODE_RESET);
  endproperty
  a_cell_clear: assert property (p_cell_clear) else $error("code not cleared on enable");

  property p_cell_decode;
    @(posedge pclk) disable iff (!presetn)
      (!rail_en && code == RSD_DCODE_500) |=> (disch_sel == RSD_DSEL_500);
  endproperty
  a_cell_decode: assert property (p_cell_decode) else $error("500 ohm code not decoded");

  property p_cell_idle;
    @(posedge pclk) disable iff (!presetn) rail_en |=> (disch_sel == RSD_DSEL_NONE);
  endproperty
  a_cell_idle: assert property (p_cell_idle) else $error("discharge active on enabled rail");

endmodule // rsd_disch_cell

/* verif/testbench.sv */
// Self-checking testbench of the rail sleep and discharge register bank
`timescale 1ns/10ps
module testbench;
  import rsd_pkg::*;

  // ****************************************
  // Signals and tables
  // ****************************************
  typedef struct packed {
    logic [RSD_AW-1:0] a;
    logic [31:0]       w;
    logic [31:0]       r;
    logic              e;
  } rsd_row_s;

  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [RSD_AW-1:0]      paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   sleep_pin_sel;
  logic                   control_in3_sleep_pin1;
  logic                   control_in6_sleep_pin2;
  logic                   aux3_pin_enable;
  logic [RSD_VCODE_W-1:0] aux3_normal_voltage_code;
  logic [RSD_VCODE_W-1:0] aux3_sleep_voltage_code;
  logic [RSD_RAILS-2:0]   other_rail_enable;
  logic                   aux3_enable;
  logic                   aux3_sleep_active;
  logic [RSD_VCODE_W-1:0] aux3_voltage_code;
  rsd_dsel_t              discharge_select;
  int                     error_cnt = 0;
  int                     compares = 0;
  int                     cyc = 0;
  logic [31:0]            rd;
  logic                   er;
  logic                   sexp;
  logic [RSD_AW-1:0]      radr [4] = '{RSD_ADDR_AUX3_CTRL, RSD_ADDR_DISCH1, RSD_ADDR_DISCH2,
                                       RSD_ADDR_DISCH3};
  logic [1:0]             dcode [11] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1, 2'h0, 2'h0,
                                         2'h1, 2'h2};
  rsd_row_s               rows [6] = '{
    '{RSD_ADDR_AUX3_CTRL, 32'h0c, 32'h0c, 1'b0},
    '{RSD_ADDR_AUX3_CTRL, 32'hfd, 32'h3d, 1'b0},
    '{RSD_ADDR_DISCH1,    32'he4, 32'he4, 1'b0},
    '{RSD_ADDR_DISCH2,    32'h1b, 32'h1b, 1'b0},
    '{RSD_ADDR_DISCH3,    32'he4, 32'h24, 1'b0},
    '{12'h0a0,            32'hff, 32'h00, 1'b1}};

  rsd_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sleep_pin_sel, .control_in3_sleep_pin1, .control_in6_sleep_pin2,
    .aux3_pin_enable, .aux3_normal_voltage_code, .aux3_sleep_voltage_code, .other_rail_enable,
    .aux3_enable, .aux3_sleep_active, .aux3_voltage_code, .discharge_select);

  // ****************************************
  // Clock, timeout and tasks
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end

  task results();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task tick(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task apb(input logic wr, input logic [RSD_AW-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [2:0] sel_of(input logic [1:0] c);
    return (c == 2'h3) ? 3'h4 : {1'b0, c};
  endfunction

  task rst_chk();
    presetn <= 1'b0;
    tick(16);
    chk(32'(aux3_enable), 32'h0, "reset enable");
    chk(32'({aux3_sleep_active, aux3_voltage_code}), 32'h0, "reset sleep");
    chk(32'(discharge_select[9:0]), 32'h0, "discharge in reset");
    chk(32'(discharge_select[10]), 32'h0, "discharge in reset");
    presetn <= 1'b1;
    foreach (radr[i]) begin
      apb(1'b0, radr[i], 32'h0);
      chk(rd, (i == 0) ? 32'h0c : 32'h0, "reset value");
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sleep_pin_sel = 1'b0;
    control_in3_sleep_pin1 = 1'b1;
    control_in6_sleep_pin2 = 1'b1;
    aux3_pin_enable = 1'b0;
    aux3_normal_voltage_code = 8'h5a;
    aux3_sleep_voltage_code = 8'ha5;
    other_rail_enable = '0;
    rst_chk();
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      chk(32'(er), 32'(rows[i].e), "write error");
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].r, "readback");
      chk(32'(er), 32'(rows[i].e), "read error");
    end
    tick(3);
    foreach (dcode[i])
      chk(32'(discharge_select[i]), 32'(sel_of(dcode[i])), "discharge path");
    aux3_pin_enable <= 1'b1;
    other_rail_enable <= '1;
    tick(4);
    chk(32'(aux3_enable), 32'h1, "aux3 on");
    apb(1'b1, RSD_ADDR_DISCH1, 32'hff);
    foreach (radr[i]) begin
      apb(1'b0, radr[i], 32'h0);
      chk(rd, (i == 0) ? 32'h3d : 32'h0, "cleared field");
    end
    other_rail_enable <= '0;
    apb(1'b1, RSD_ADDR_DISCH3, 32'h3f);
    apb(1'b0, RSD_ADDR_DISCH3, 32'h0);
    chk(rd, 32'h3c, "aux3 field held clear");
    apb(1'b1, RSD_ADDR_AUX3_CTRL, 32'h3c);
    tick(3);
    chk(32'(aux3_enable), 32'h0, "forced off");
    apb(1'b1, RSD_ADDR_DISCH3, 32'h3f);
    tick(3);
    chk(32'(discharge_select[8]), 32'h4, "aux3 discharge");
    chk(32'(discharge_select[10]), 32'h4, "switch b2 discharge");
    apb(1'b1, RSD_ADDR_AUX3_CTRL, 32'h3d);
    tick(4);
    chk(32'(discharge_select[8]), 32'h0, "enabled aux3 discharge");
    apb(1'b0, RSD_ADDR_DISCH3, 32'h0);
    chk(rd, 32'h3c, "aux3 field cleared");
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 8; k++) begin
        apb(1'b1, RSD_ADDR_AUX3_CTRL, {26'h0, (s == 1) ? 2'h3 : 2'h0, 4'hd});
        sleep_pin_sel <= k[2];
        control_in3_sleep_pin1 <= k[1];
        control_in6_sleep_pin2 <= k[0];
        tick(3);
        sexp = (s == 1) && !(k[2] ? k[0] : k[1]);
        chk(32'(aux3_sleep_active), 32'(sexp), "sleep state");
        chk(32'(aux3_voltage_code), sexp ? 32'ha5 : 32'h5a, "voltage code");
      end
    end
    rst_chk();
    results();
  end
endmodule // testbench
